// ===== shared/spm_pkg.sv
// constants for the serial port mode configuration block
// assumes one 250 MHz core clock and an Avalon-MM byte address
// Operation
// - bit 0 of each port mode register turns MIDI support on, off after reset.
// - bit 1 of each port mode register turns high-speed operation on, off after reset.
// - bit 7 of the first mode register makes both UARTs share one interrupt request.
// - with sharing on and both UARTs assigned, both interrupt lines follow either UART.
// - bit 5 of the second mode register picks a low or released idle transmit pin.
// - the idle selection bit is cleared only by the standby supply power-on reset.
// - bit 0 of the infrared option register makes the receive input active low.
// - bit 1 of the infrared option register makes the transmit output active low.
// - bit 2 of the infrared option register selects half duplex instead of full, in IrDA and amplitude keyed modes only.
// - bits 5 to 3 pick standard serial, IrDA or amplitude keyed infrared.
// - bit 6 moves the infrared signals onto the alternate dedicated pins.
// - the timeout register counts blanking extension in 100 us steps, reset value 3.
// - a timeout of zero blanks only while transmitting, each count up to 100 adds one step.
package spm_pkg;
  // register indices, byte address is {bank, index, 2'b00}
  localparam logic [7:0] SPM_IDX_MODE = 8'hF0;
  localparam logic [7:0] SPM_IDX_IR_OPT = 8'hF1;
  localparam logic [7:0] SPM_IDX_HD_TMO = 8'hF2;
  localparam logic [7:0] SPM_IDX_INT_STAT = 8'h00;
  localparam logic [7:0] SPM_IDX_INT_MASK = 8'h01;
  localparam logic [7:0] SPM_IDX_LIVE = 8'h02;
  localparam logic SPM_BANK_P1 = 1'h0;
  localparam logic SPM_BANK_P2 = 1'h1;
  // reset values and writable bit masks
  localparam logic [7:0] SPM_MODE_RST = 8'h00;
  localparam logic [7:0] SPM_IR_OPT_RST = 8'h02;
  localparam logic [7:0] SPM_HD_TMO_RST = 8'h03;
  localparam logic [7:0] SPM_P1_WMASK = 8'h83;
  localparam logic [7:0] SPM_P2_WMASK = 8'h03;
  localparam logic [7:0] SPM_IR_WMASK = 8'h7F;
  // field positions
  localparam int SPM_B_MIDI = 0;
  localparam int SPM_B_HS = 1;
  localparam int SPM_B_SHARE = 7;
  localparam int SPM_B_TXIDLE = 5;
  localparam int SPM_B_RXPOL = 0;
  localparam int SPM_B_TXPOL = 1;
  localparam int SPM_B_DUPLEX = 2;
  localparam int SPM_B_IRMODE = 3;
  localparam int SPM_B_ROUTE = 6;
  // interrupt status bits
  localparam int SPM_EV_W = 3;
  localparam int SPM_EV_U1 = 0;
  localparam int SPM_EV_U2 = 1;
  localparam int SPM_EV_BLANK = 2;
  // timing: one blanking step
  localparam int SPM_CLK_MHZ = 250;
  localparam int SPM_STEP_US = 100;
  localparam int SPM_STEP_CYCLES = SPM_STEP_US * SPM_CLK_MHZ;
  localparam logic [7:0] SPM_TMO_MAX = 8'h64;
  typedef enum logic [2:0] {
    SPM_IR_STD = 3'b000,
    SPM_IR_IRDA = 3'b001,
    SPM_IR_ASK = 3'b010
  } spm_ir_mode_t;
  typedef enum logic {
    SPM_BUS_IDLE = 1'b0,
    SPM_BUS_ACK = 1'b1
  } spm_bus_state_t;
endpackage

// ===== design/spm_blank_timer.sv
// half-duplex receive blanking timer
// assumes a synchronous transmit busy level from the second UART
module spm_blank_timer import spm_pkg::*; #(
  parameter int STEP_CYCLES = SPM_STEP_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_half_duplex,
  input wire logic i_tx_busy,
  input wire logic [7:0] i_steps,
  output logic o_blank
);
  typedef struct packed {
    logic [15:0] cyc;
    logic [7:0] left;
    logic blank;
  } spm_tmr_t;
  spm_tmr_t st_reg, st_next;
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  // step counter, values above 10 ms clamp to the maximum
  always_comb begin
    st_next = st_reg;
    if (!i_half_duplex) begin
      st_next = '0;
    end else if (i_tx_busy) begin
      st_next.blank = 1'b1;
      st_next.cyc = '0;
      st_next.left = (i_steps > SPM_TMO_MAX) ? SPM_TMO_MAX : i_steps;
    end else if (st_reg.left != 8'h00) begin
      st_next.blank = 1'b1;
      st_next.cyc = st_reg.cyc + 16'h0001;
      if (st_reg.cyc == STEP_LAST) begin
        st_next.cyc = '0;
        st_next.left = st_reg.left - 8'h01;
      end
    end else begin
      st_next.blank = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_blank = st_reg.blank;
endmodule

// ===== design/spm_ir_route.sv
// second port pin router: serial or infrared, normal or alternate pins
// assumes pins synchronous to the core clock, encoders live in the UART
module spm_ir_route import spm_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_data,
  input wire logic i_port_active,
  input wire logic i_idle_tristate,
  input wire logic [2:0] i_ir_mode,
  input wire logic i_tx_pol_low,
  input wire logic i_rx_pol_low,
  input wire logic i_alt_pins,
  input wire logic i_blank,
  input wire logic i_serial_in,
  input wire logic i_alt_rx,
  output logic o_serial_out,
  output logic o_serial_oe,
  output logic o_alt_tx,
  output logic o_rx_data
);
  typedef struct packed {
    logic sout;
    logic soe;
    logic atx;
    logic rx;
  } spm_rt_t;
  spm_rt_t st_reg, st_next;
  logic ir;
  logic tx_lvl;
  logic rx_src;

  // reserved mode codes fall back to plain serial
  always_comb begin
    ir = (i_ir_mode == SPM_IR_IRDA) || (i_ir_mode == SPM_IR_ASK);
    tx_lvl = ~i_tx_data ^ i_tx_pol_low;
    rx_src = (ir && i_alt_pins) ? i_alt_rx : i_serial_in;
    st_next.atx = (ir && i_alt_pins && i_port_active) ? tx_lvl : i_tx_pol_low;
    st_next.soe = 1'b1;
    st_next.sout = i_tx_data;
    if (!i_port_active) begin
      st_next.sout = 1'b0;
      st_next.soe = !i_idle_tristate;
    end else if (ir && !i_alt_pins) begin
      st_next.sout = tx_lvl;
    end
    st_next.rx = ir ? ~(rx_src ^ i_rx_pol_low) : rx_src;
    if (i_blank) begin
      st_next.rx = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{sout: 1'b0, soe: 1'b1, atx: 1'b1, rx: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_serial_out = st_reg.sout;
  assign o_serial_oe = st_reg.soe;
  assign o_alt_tx = st_reg.atx;
  assign o_rx_data = st_reg.rx;
endmodule

// ===== design/spm_top.sv
// serial port mode registers, IRQ sharing and second port pin control
// assumes an Avalon-MM master on the core clock and UART cores outside
module spm_top import spm_pkg::*; #(
  parameter int STEP_CYCLES = SPM_STEP_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_standby_rstn,
  input wire logic [10:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_uart1_irq,
  input wire logic i_uart2_irq,
  input wire logic i_uart1_irq_assigned,
  input wire logic i_uart2_irq_assigned,
  output logic o_uart1_irq_line,
  output logic o_uart2_irq_line,
  output logic o_p1_midi_en,
  output logic o_p1_high_speed,
  output logic o_p2_midi_en,
  output logic o_p2_high_speed,
  input wire logic i_p2_port_active,
  input wire logic i_p2_tx_data,
  input wire logic i_p2_tx_busy,
  output logic o_p2_rx_data,
  input wire logic i_second_port_serial_in,
  output logic o_second_port_serial_out,
  output logic o_second_port_serial_oe,
  input wire logic i_alt_infrared_receive_pin,
  output logic o_alt_infrared_transmit_pin,
  output logic o_irq
);
  typedef struct packed {
    spm_bus_state_t bus;
    logic wreq;
    logic [31:0] rdata;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] ir;
    logic [7:0] tmo;
    logic [SPM_EV_W-1:0] stat;
    logic [SPM_EV_W-1:0] mask;
    logic irq;
    logic line1;
    logic line2;
    logic u1_prev;
    logic u2_prev;
    logic blank_prev;
  } spm_top_st_t;

  spm_top_st_t st_reg, st_next;
  logic [1:0] rst_sync_reg;
  logic [1:0] srst_sync_reg;
  logic rst_n;
  logic srst_n;
  logic tx_idle_reg;
  logic blank;
  logic half;
  logic bank;
  logic [7:0] idx;
  logic wr_go;
  logic wr_p2mode;
  logic any_irq;
  logic [SPM_EV_W-1:0] ev;
  logic [SPM_EV_W-1:0] w1c;
  logic [31:0] rd_val;

  // reset release through two flops each, assertion stays asynchronous
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_standby_rstn) begin
    if (!i_standby_rstn) begin
      srst_sync_reg <= 2'h0;
    end else begin
      srst_sync_reg <= {srst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];
  assign srst_n = srst_sync_reg[1];

  // address split and write qualification
  assign bank = i_avs_address[10];
  assign idx = i_avs_address[9:2];
  assign wr_go = (st_reg.bus == SPM_BUS_ACK) && i_avs_write && i_avs_byteenable[0];
  assign wr_p2mode = wr_go && (bank == SPM_BANK_P2) && (idx == SPM_IDX_MODE);
  assign half = st_reg.ir[SPM_B_DUPLEX] &&
    ((st_reg.ir[5:3] == SPM_IR_IRDA) || (st_reg.ir[5:3] == SPM_IR_ASK));

  // read mux, reserved bits and unmapped addresses read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (bank == SPM_BANK_P1 && idx == SPM_IDX_MODE) begin
      rd_val[7:0] = st_reg.p1;
    end else if (bank == SPM_BANK_P1 && idx == SPM_IDX_INT_STAT) begin
      rd_val[SPM_EV_W-1:0] = st_reg.stat;
    end else if (bank == SPM_BANK_P1 && idx == SPM_IDX_INT_MASK) begin
      rd_val[SPM_EV_W-1:0] = st_reg.mask;
    end else if (bank == SPM_BANK_P1 && idx == SPM_IDX_LIVE) begin
      rd_val[2:0] = {blank, st_reg.line2, st_reg.line1};
    end else if (bank == SPM_BANK_P2 && idx == SPM_IDX_MODE) begin
      rd_val[7:0] = st_reg.p2;
      rd_val[SPM_B_TXIDLE] = tx_idle_reg;
    end else if (bank == SPM_BANK_P2 && idx == SPM_IDX_IR_OPT) begin
      rd_val[7:0] = st_reg.ir;
    end else if (bank == SPM_BANK_P2 && idx == SPM_IDX_HD_TMO) begin
      rd_val[7:0] = st_reg.tmo;
    end
  end

  // main next-state logic: bus handshake, registers, irq routing, events
  always_comb begin
    st_next = st_reg;
    w1c = '0;
    any_irq = i_uart1_irq | i_uart2_irq;
    // one wait cycle, then a single ack cycle with waitrequest low
    if (st_reg.bus == SPM_BUS_IDLE) begin
      if (i_avs_read || i_avs_write) begin
        st_next.bus = SPM_BUS_ACK;
        st_next.wreq = 1'b0;
        st_next.rdata = rd_val;
      end
    end else begin
      st_next.bus = SPM_BUS_IDLE;
      st_next.wreq = 1'b1;
    end
    // reserved bits are masked off, software should write them as zero
    if (wr_go) begin
      if (bank == SPM_BANK_P1 && idx == SPM_IDX_MODE) begin
        st_next.p1 = i_avs_writedata[7:0] & SPM_P1_WMASK;
      end else if (bank == SPM_BANK_P1 && idx == SPM_IDX_INT_STAT) begin
        w1c = i_avs_writedata[SPM_EV_W-1:0];
      end else if (bank == SPM_BANK_P1 && idx == SPM_IDX_INT_MASK) begin
        st_next.mask = i_avs_writedata[SPM_EV_W-1:0];
      end else if (bank == SPM_BANK_P2 && idx == SPM_IDX_MODE) begin
        st_next.p2 = i_avs_writedata[7:0] & SPM_P2_WMASK;
      end else if (bank == SPM_BANK_P2 && idx == SPM_IDX_IR_OPT) begin
        st_next.ir = i_avs_writedata[7:0] & SPM_IR_WMASK;
      end else if (bank == SPM_BANK_P2 && idx == SPM_IDX_HD_TMO) begin
        st_next.tmo = i_avs_writedata[7:0];
      end
    end
    // sharing relies on software leaving one UART unassigned
    if (st_reg.p1[SPM_B_SHARE]) begin
      st_next.line1 = i_uart1_irq_assigned & any_irq;
      st_next.line2 = i_uart2_irq_assigned & any_irq;
    end else begin
      st_next.line1 = i_uart1_irq;
      st_next.line2 = i_uart2_irq;
    end
    // rising irq edges and the end of blanking; a new event beats the clear
    st_next.u1_prev = i_uart1_irq;
    st_next.u2_prev = i_uart2_irq;
    st_next.blank_prev = blank;
    ev = '0;
    ev[SPM_EV_U1] = i_uart1_irq & ~st_reg.u1_prev;
    ev[SPM_EV_U2] = i_uart2_irq & ~st_reg.u2_prev;
    ev[SPM_EV_BLANK] = st_reg.blank_prev & ~blank;
    st_next.stat = (st_reg.stat & ~w1c) | ev;
    st_next.irq = |(st_next.stat & st_next.mask);
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{bus: SPM_BUS_IDLE, wreq: 1'b1, rdata: 32'h0000_0000,
        p1: SPM_MODE_RST, p2: SPM_MODE_RST, ir: SPM_IR_OPT_RST,
        tmo: SPM_HD_TMO_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // idle-level bit sits on the standby supply, main resets leave it alone
  always_ff @(posedge i_core_clk or negedge srst_n) begin
    if (!srst_n) begin
      tx_idle_reg <= 1'b0;
    end else if (wr_p2mode) begin
      tx_idle_reg <= i_avs_writedata[SPM_B_TXIDLE];
    end
  end

  spm_blank_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_half_duplex(half),
    .i_tx_busy(i_p2_tx_busy),
    .i_steps(st_reg.tmo),
    .o_blank(blank)
  );

  spm_ir_route u_route (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_tx_data(i_p2_tx_data),
    .i_port_active(i_p2_port_active),
    .i_idle_tristate(tx_idle_reg),
    .i_ir_mode(st_reg.ir[5:3]),
    .i_tx_pol_low(st_reg.ir[SPM_B_TXPOL]),
    .i_rx_pol_low(st_reg.ir[SPM_B_RXPOL]),
    .i_alt_pins(st_reg.ir[SPM_B_ROUTE]),
    .i_blank(blank),
    .i_serial_in(i_second_port_serial_in),
    .i_alt_rx(i_alt_infrared_receive_pin),
    .o_serial_out(o_second_port_serial_out),
    .o_serial_oe(o_second_port_serial_oe),
    .o_alt_tx(o_alt_infrared_transmit_pin),
    .o_rx_data(o_p2_rx_data)
  );

  // all outputs straight from flops
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.wreq;
  assign o_uart1_irq_line = st_reg.line1;
  assign o_uart2_irq_line = st_reg.line2;
  assign o_p1_midi_en = st_reg.p1[SPM_B_MIDI];
  assign o_p1_high_speed = st_reg.p1[SPM_B_HS];
  assign o_p2_midi_en = st_reg.p2[SPM_B_MIDI];
  assign o_p2_high_speed = st_reg.p2[SPM_B_HS];
  assign o_irq = st_reg.irq;

  // checks on the core clock, quiet while the main reset is held, except idle_keep_a
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  midi_write_a: assert property (
    wr_go && bank == SPM_BANK_P1 && idx == SPM_IDX_MODE
    |=> o_p1_midi_en == $past(i_avs_writedata[0]))
    else $error("midi enable did not follow the mode write");

  speed_write_a: assert property (
    wr_go && bank == SPM_BANK_P2 && idx == SPM_IDX_MODE
    |=> o_p2_high_speed == $past(i_avs_writedata[1]))
    else $error("high speed did not follow the mode write");

  separate_irq_a: assert property (
    !st_reg.p1[SPM_B_SHARE] |=> o_uart2_irq_line == $past(i_uart2_irq))
    else $error("unshared line does not follow its own uart");

  shared_both_a: assert property (
    st_reg.p1[SPM_B_SHARE] && i_uart1_irq_assigned && i_uart2_irq_assigned
    && any_irq |=> o_uart1_irq_line && o_uart2_irq_line)
    else $error("shared irq did not raise both lines");

  idle_low_a: assert property (
    !i_p2_port_active && !tx_idle_reg
    |=> o_second_port_serial_oe && !o_second_port_serial_out)
    else $error("idle transmit pin not driven low");

  idle_keep_a: assert property (@(posedge i_core_clk) disable iff (!srst_n)
    !rst_n |-> $stable(tx_idle_reg))
    else $error("main reset disturbed the idle level bit");

  rx_polarity_a: assert property (
    st_reg.ir[5:3] == SPM_IR_IRDA && !st_reg.ir[SPM_B_ROUTE] && !blank
    && !st_reg.ir[SPM_B_RXPOL]
    |=> o_p2_rx_data == !$past(i_second_port_serial_in))
    else $error("active high receive not inverted to uart");

  alt_route_a: assert property (
    st_reg.ir[5:3] == SPM_IR_IRDA && st_reg.ir[SPM_B_ROUTE] && i_p2_port_active
    |=> o_alt_infrared_transmit_pin
    == ($past(~i_p2_tx_data) ^ $past(st_reg.ir[SPM_B_TXPOL])))
    else $error("alternate transmit pin wrong");

  full_duplex_a: assert property (
    !half |=> !blank)
    else $error("blanking in full duplex");

  zero_tmo_a: assert property (
    half && $past(half) && $fell(i_p2_tx_busy) && $past(st_reg.tmo) == 8'h00
    |=> !blank ##1 (!blank || $past(i_p2_tx_busy)))
    else $error("zero timeout kept blanking");

  blank_rx_a: assert property (
    blank |=> o_p2_rx_data)
    else $error("receive not held idle while blanked");

  p1_speed_a: assert property (
    wr_go && bank == SPM_BANK_P1 && idx == SPM_IDX_MODE
    |=> o_p1_high_speed == $past(i_avs_writedata[1]))
    else $error("first port high speed did not follow the write");

  p2_midi_a: assert property (
    wr_go && bank == SPM_BANK_P2 && idx == SPM_IDX_MODE
    |=> o_p2_midi_en == $past(i_avs_writedata[0]))
    else $error("second port midi enable did not follow the write");

  share_one_a: assert property (
    st_reg.p1[SPM_B_SHARE] && i_uart1_irq_assigned && !i_uart2_irq_assigned
    && i_uart2_irq |=> o_uart1_irq_line && !o_uart2_irq_line)
    else $error("shared irq not carried on the assigned line");

  idle_float_a: assert property (
    !i_p2_port_active && tx_idle_reg |=> !o_second_port_serial_oe)
    else $error("idle transmit pin not released");

  tx_inactive_a: assert property (
    !st_reg.ir[SPM_B_ROUTE]
    |=> o_alt_infrared_transmit_pin == $past(st_reg.ir[SPM_B_TXPOL]))
    else $error("unused alternate pin not at its inactive level");

  std_mode_a: assert property (
    st_reg.ir[5:3] != SPM_IR_IRDA && st_reg.ir[5:3] != SPM_IR_ASK && i_p2_port_active
    |=> o_second_port_serial_out == $past(i_p2_tx_data))
    else $error("standard mode transmit pin not plain");

  alt_receive_a: assert property (
    st_reg.ir[5:3] == SPM_IR_IRDA && st_reg.ir[SPM_B_ROUTE] && !blank
    && !st_reg.ir[SPM_B_RXPOL]
    |=> o_p2_rx_data == !$past(i_alt_infrared_receive_pin))
    else $error("alternate receive pin not used");

  blank_start_a: assert property (
    half && i_p2_tx_busy |=> blank)
    else $error("transmit did not start blanking");

  // handshake and sticky status; a new event must beat a clear in one cycle
  ack_once_a: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  bus_accept_a: assert property (
    st_reg.bus == SPM_BUS_IDLE && (i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");

  event_wins_a: assert property (
    i_uart1_irq && !st_reg.u1_prev |=> st_reg.stat[SPM_EV_U1])
    else $error("irq edge lost against a clear");

  status_sticky_a: assert property (
    st_reg.stat[SPM_EV_U1] && !wr_go |=> st_reg.stat[SPM_EV_U1])
    else $error("status bit dropped without a clear");

  share_c: cover property (st_reg.p1[SPM_B_SHARE] && o_uart1_irq_line && o_uart2_irq_line);
  blank_end_c: cover property (st_reg.stat[SPM_EV_BLANK]);
  write_c: cover property (wr_go);
  irq_c: cover property (o_irq);
  tmo_ext_c: cover property (blank && !i_p2_tx_busy);
endmodule

// ===== bench/spm_line_model.sv
// far-side model: serial line or infrared transceiver on the second port
// assumes a board pull-up on the transmit pin, so a released pin reads high
module spm_line_model (
  input wire logic i_tx_out,
  input wire logic i_tx_oe,
  input wire logic i_level,
  output logic o_serial_in,
  output logic o_alt_rx,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // alt receiver sees the opposite level so a wrong pin choice shows up
  assign o_serial_in = i_level;
  assign o_alt_rx = ~i_level;
  // a released pin floats to the pull-up, never keeps the last value
  assign o_line = i_tx_oe ? i_tx_out : 1'b1;
endmodule

// ===== bench/tb.sv
// self-checking bench for the serial port mode block over Avalon-MM
// assumes a short blanking step passed in through the top parameter
module tb import spm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  logic clk = 0, rstn = 0, sb_rstn = 0, rd = 0, wr = 0, wreq, irq;
  logic [10:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [3:0] be = '0;
  logic irq1 = 0, irq2 = 0, as1 = 0, as2 = 0, line1, line2, p1m, p1h, p2m, p2h;
  logic act = 0, txd = 0, busy = 0, rxd, sin, sout, soe, arx, atx, lvl = 1, line;
  logic tp, rp, et, ea, er, src, ir;
  int n_errors = 0, check_count = 0;
  spm_top #(.STEP_CYCLES(STEP)) i_dut (.i_core_clk(clk), .i_rstn(rstn),
    .i_standby_rstn(sb_rstn), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_uart1_irq(irq1), .i_uart2_irq(irq2),
    .i_uart1_irq_assigned(as1), .i_uart2_irq_assigned(as2), .o_uart1_irq_line(line1),
    .o_uart2_irq_line(line2), .o_p1_midi_en(p1m), .o_p1_high_speed(p1h),
    .o_p2_midi_en(p2m), .o_p2_high_speed(p2h), .i_p2_port_active(act),
    .i_p2_tx_data(txd), .i_p2_tx_busy(busy), .o_p2_rx_data(rxd),
    .i_second_port_serial_in(sin), .o_second_port_serial_out(sout),
    .o_second_port_serial_oe(soe), .i_alt_infrared_receive_pin(arx),
    .o_alt_infrared_transmit_pin(atx), .o_irq(irq));
  spm_line_model i_line (.i_tx_out(sout), .i_tx_oe(soe), .i_level(lvl),
    .o_serial_in(sin), .o_alt_rx(arx), .o_line(line));
  // 250 MHz core clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one access; held until waitrequest is seen low at a rising edge
  // no wait count assumed, the watchdog ends a hang
  task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] d,
                     input logic [3:0] e);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= {24'h0, d};
    be <= e;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [10:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rchk(input logic [10:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(q, e);
  endtask
  // blanking span after transmit ends, counted in cycles of forced mark
  task automatic blank(input logic [7:0] t, input logic [7:0] opt, input int lo, input int hi);
    int n;
    wreg(11'h7C8, t);
    wreg(11'h7C4, opt);
    lvl <= 1'b1;
    tick(3);
    busy <= 1'b1;
    tick(5);
    if (lo > 0) chk(rxd, 1'b1);
    busy <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rxd === 1'b1 && n < 300);
    chk(32'(n - 1 >= lo && n - 1 <= hi), 32'h1);
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  initial begin
    tick(3);
    rstn <= 1'b1;
    sb_rstn <= 1'b1;
    tick(3);
    rchk(11'h3C0, 32'h00);
    rchk(11'h7C0, 32'h00);
    rchk(11'h7C4, 32'h02);
    rchk(11'h7C8, 32'h03);
    rchk(11'h100, 32'h00);
    bus(1'b1, 11'h7C8, 8'h55, 4'h0);
    rchk(11'h7C8, 32'h03);
    // reserved bits must stay zero whatever is written
    wreg(11'h3C0, 8'h7F);
    rchk(11'h3C0, 32'h03);
    chk({p1m, p1h}, 2'b11);
    wreg(11'h7C0, 8'hDF);
    rchk(11'h7C0, 32'h03);
    chk({p2m, p2h}, 2'b11);
    // sticky status, mask and clear
    wreg(11'h000, 8'h07);
    irq1 <= 1'b1;
    tick(3);
    rchk(11'h000, 32'h01);
    chk(irq, 1'b0);
    wreg(11'h004, 8'h01);
    tick(2);
    chk(irq, 1'b1);
    chk({line1, line2}, 2'b10);
    wreg(11'h000, 8'h01);
    tick(2);
    chk(irq, 1'b0);
    // sharing in the documented order: one line, then both
    irq1 <= 1'b0;
    as1 <= 1'b1;
    wreg(11'h3C0, 8'h80);
    irq2 <= 1'b1;
    tick(3);
    chk({line1, line2}, 2'b10);
    as2 <= 1'b1;
    tick(3);
    chk({line1, line2}, 2'b11);
    irq2 <= 1'b0;
    tick(3);
    chk({line1, line2}, 2'b00);
    // idle level of the transmit pin and its standby-only reset
    wreg(11'h7C0, 8'h00);
    tick(2);
    chk({soe, sout}, 2'b10);
    wreg(11'h7C0, 8'h20);
    tick(2);
    chk({soe, line}, 2'b01);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(3);
    rchk(11'h7C0, 32'h20);
    sb_rstn <= 1'b0;
    tick(2);
    sb_rstn <= 1'b1;
    tick(3);
    rchk(11'h7C0, 32'h00);
    chk({soe, sout}, 2'b10);
    // function codes 000 to 011, reserved 011 too, polarity and pin choice
    act <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int al = 0; al < 2; al++) begin
        tp = al[0];
        rp = ~al[0];
        ir = (m == 1 || m == 2);
        wreg(11'h7C4, {1'b0, al[0], m[2:0], 1'b0, tp, rp});
        for (int k = 0; k < 4; k++) begin
          txd <= k[0];
          lvl <= k[1];
          tick(3);
          src = (al[0] && ir) ? ~k[1] : k[1];
          et = (ir && !al[0]) ? ~k[0] ^ tp : k[0];
          ea = (ir && al[0]) ? ~k[0] ^ tp : tp;
          er = ir ? ~(src ^ rp) : src;
          chk(sout, et);
          chk(atx, ea);
          chk(rxd, er);
        end
      end
    end
    wreg(11'h000, 8'h07);
    blank(8'h00, 8'h0C, 0, 3);
    blank(8'h02, 8'h0C, 2 * STEP, 2 * STEP + 3);
    rchk(11'h000, 32'h04);
    blank(8'h02, 8'h08, 0, 0);
    wrap_up();
  end
endmodule
